// *** logic/ade_pkg.sv ***
package ade_pkg;

    // ------------------------------------------------------------
    // operations issued by the core
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_BYTE_DOT_SUB_LEFT,
        OP_BYTE_DOT_SUB_RIGHT,
        OP_HALF_CROSS_DOT_SUB,
        OP_FIXED_FIELD_EXTRACT,
        OP_FIXED_FIELD_EXTRACT_DECREMENT
    } ade_op_e;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h08;
    localparam logic [7:0] ADDR_ACC_LO0 = 8'h10;
    localparam logic [7:0] ADDR_ACC_END = 8'h30;
    localparam int         ACC_COUNT    = 4;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          POS_LSB     = 0;
    localparam int          POS_MSB     = 5;
    localparam int          EFI_BIT     = 14;
    localparam int          OUF_LSB     = 16;
    localparam int          OUF_MSB     = 23;
    localparam logic [31:0] CTL_WMASK   = 32'h00ff403f;
    localparam logic [31:0] CTL_RESET   = 32'h00000000;

    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int         IRQ_EXT_FAIL = 0;
    localparam int         IRQ_OP_DONE  = 1;
    localparam int         IRQ_W        = 2;

    // ------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // complete block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ACC_COUNT-1:0][63:0] acc;
        logic [31:0]                ctl;
        logic [IRQ_W-1:0]           sts;
        logic [IRQ_W-1:0]           msk;
        logic                       irq;
        logic                       resValid;
        logic [31:0]                resData;
        logic                       resFail;
        logic                       awHeld;
        logic [7:0]                 awAddr;
        logic                       wHeld;
        logic [31:0]                wData;
        logic [3:0]                 wStrb;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
    } ade_state_s;

endpackage

// *** logic/ade_core.sv ***
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// RQ1 - left byte lanes: unsigned products subtracted
// RQ2 - right byte lanes: unsigned products subtracted
// RQ3 - four accumulators, index zero is legacy pair
// RQ4 - dot-subtracts keep overflow flags, never saturate
// RQ5 - cross halfword signed products subtracted, sign-extended
// RQ6 - extract size+1 bits, zero-extended to result
// RQ7 - start position from control bits five..zero
// RQ8 - valid when position minus size+1 >= -1
// RQ9 - failed flag bit fourteen set on failure
// RQ10 - extracts leave accumulator contents untouched
// RQ11 - plain extract leaves position field unchanged
// RQ12 - decrementing extract lowers position by size+1
// RQ13 - failed decrementing extract keeps position, sets flag
// RQ14 - extract size comes from instruction immediate
// RQ15 - no data-dependent exceptions, only flags
// RQ16 - core supplies operands in expected format
// RQ17 - high word upper half, wraps modulo 2^64
module ade_core
(
    input  wire logic            clk,
    input  wire logic            nrst,
    input  wire logic            ce,
    input  wire logic            opValid,
    input  ade_pkg::ade_op_e     opCode,
    input  wire logic [1:0]      accSel,
    input  wire logic [31:0]     srcOne,
    input  wire logic [31:0]     srcTwo,
    input  wire logic [4:0]      sizeImm,
    output logic                 resultValid,
    output logic [31:0]          resultData,
    output logic                 extractFailed,
    output logic                 irq,
    input  wire logic [31:0]     s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [31:0]     s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] applyStrb(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction

    // true when the address names an accumulator word
    function automatic logic isAccAddr(input logic [7:0] a);
        return (a >= ade_pkg::ADDR_ACC_LO0) && (a < ade_pkg::ADDR_ACC_END);
    endfunction

    ade_pkg::ade_state_s r;
    ade_pkg::ade_state_s next_r;

    logic              go;
    logic              busWr;
    logic [63:0]       curAcc;
    logic [5:0]        pos;
    logic [15:0]       prodLeftA;
    logic [15:0]       prodLeftB;
    logic [15:0]       prodRightA;
    logic [15:0]       prodRightB;
    logic signed [31:0] prodCrossB;
    logic signed [31:0] prodCrossA;
    logic [63:0]       dotLeft;
    logic [63:0]       dotRight;
    logic [63:0]       dotCross;
    logic              extValid;
    logic [63:0]       shifted;
    logic [63:0]       fieldMask;
    logic [31:0]       field;
    logic [7:0]        rdAddr;
    logic [1:0]        accIdx;

    assign go     = opValid && ce;
    assign curAcc = r.acc[accSel];                           // see RQ3
    assign pos    = r.ctl[ade_pkg::POS_MSB:ade_pkg::POS_LSB]; // see RQ7

    // ------------------------------------------------------------
    // dot products
    // ------------------------------------------------------------
    assign prodLeftB  = srcOne[31:24] * srcTwo[31:24];       // see RQ1
    assign prodLeftA  = srcOne[23:16] * srcTwo[23:16];       // see RQ1
    assign dotLeft    = {48'h0, prodLeftB} + {48'h0, prodLeftA};
    assign prodRightB = srcOne[15:8] * srcTwo[15:8];         // see RQ2
    assign prodRightA = srcOne[7:0] * srcTwo[7:0];           // see RQ2
    assign dotRight   = {48'h0, prodRightB} + {48'h0, prodRightA};
    assign prodCrossB = $signed(srcOne[31:16]) * $signed(srcTwo[15:0]);
    assign prodCrossA = $signed(srcOne[15:0]) * $signed(srcTwo[31:16]);
    // each product is sign-extended to 64 bits before the add, so no wrap in the dot term
    assign dotCross   = {{32{prodCrossB[31]}}, prodCrossB}   // see RQ5
                      + {{32{prodCrossA[31]}}, prodCrossA};

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    // pos-(size+1) >= -1 reduces to pos >= size
    assign extValid  = {1'b0, pos} >= {2'h0, sizeImm};       // see RQ8
    assign shifted   = curAcc >> (pos - {1'b0, sizeImm});    // see RQ14
    assign fieldMask = ~(64'hffffffffffffffff << ({1'b0, sizeImm} + 6'h1));
    assign field     = shifted[31:0] & fieldMask[31:0];      // see RQ6

    assign rdAddr = s_axi_araddr[7:0];
    assign accIdx = rdAddr[4:3] - 2'h2;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [1:0]           setEv;
        logic [1:0]           wIdx;
        logic [31:0]          wOld;
        logic [31:0]          wNew;
        logic [63:0]          accW;
        setEv  = '0;
        wIdx   = '0;
        wOld   = '0;
        wNew   = '0;
        accW   = '0;
        next_r = r;
        busWr  = 1'b0;

        // write channels are taken independently, then joined
        if (s_axi_awvalid && r.awready)
        begin
            next_r.awHeld = 1'b1;
            next_r.awAddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && r.wready)
        begin
            next_r.wHeld = 1'b1;
            next_r.wData = s_axi_wdata;
            next_r.wStrb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready)
        begin
            next_r.bvalid = 1'b0;
        end
        if (r.awHeld && r.wHeld && !r.bvalid)
        begin
            busWr         = 1'b1;
            next_r.awHeld = 1'b0;
            next_r.wHeld  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = ade_pkg::RESP_OKAY;
            if (r.awAddr == ade_pkg::ADDR_CONTROL)
            begin
                wNew = applyStrb(r.ctl, r.wData, r.wStrb);
                next_r.ctl = wNew & ade_pkg::CTL_WMASK;
            end
            else if (r.awAddr == ade_pkg::ADDR_IRQ_STS)
            begin
                wNew = applyStrb(32'h0, r.wData, r.wStrb);
                next_r.sts = r.sts & ~wNew[ade_pkg::IRQ_W-1:0];
            end
            else if (r.awAddr == ade_pkg::ADDR_IRQ_MSK)
            begin
                wOld = {30'h0, r.msk};
                wNew = applyStrb(wOld, r.wData, r.wStrb);
                next_r.msk = wNew[ade_pkg::IRQ_W-1:0];
            end
            else if (isAccAddr(r.awAddr))
            begin
                wIdx = r.awAddr[4:3] - 2'h2;
                accW = r.acc[wIdx];
                if (r.awAddr[2])
                begin
                    accW[63:32] = applyStrb(accW[63:32], r.wData, r.wStrb);
                end
                else
                begin
                    accW[31:0] = applyStrb(accW[31:0], r.wData, r.wStrb);
                end
                next_r.acc[wIdx] = accW;
            end
            else
            begin
                next_r.bresp = ade_pkg::RESP_SLVERR;
            end
        end
        next_r.awready = !next_r.awHeld && !next_r.bvalid;
        next_r.wready  = !next_r.wHeld && !next_r.bvalid;

        // read channel
        if (r.rvalid && s_axi_rready)
        begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r.arready)
        begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = ade_pkg::RESP_OKAY;
            next_r.rdata  = '0;
            if (rdAddr == ade_pkg::ADDR_CONTROL)
            begin
                next_r.rdata = r.ctl;
            end
            else if (rdAddr == ade_pkg::ADDR_IRQ_STS)
            begin
                next_r.rdata = {30'h0, r.sts};
            end
            else if (rdAddr == ade_pkg::ADDR_IRQ_MSK)
            begin
                next_r.rdata = {30'h0, r.msk};
            end
            else if (isAccAddr(rdAddr))
            begin
                next_r.rdata = rdAddr[2] ? r.acc[accIdx][63:32]
                                         : r.acc[accIdx][31:0];  // see RQ17
            end
            else
            begin
                next_r.rresp = ade_pkg::RESP_SLVERR;
            end
        end
        next_r.arready = !next_r.rvalid;

        // core operation overrides a same-cycle bus write of its fields
        next_r.resValid = go;
        if (go)
        begin
            setEv[ade_pkg::IRQ_OP_DONE] = 1'b1;
            unique case (opCode)
                ade_pkg::OP_BYTE_DOT_SUB_LEFT:
                begin
                    next_r.acc[accSel] = curAcc - dotLeft;   // see RQ1
                    next_r.resData     = '0;
                    next_r.resFail     = 1'b0;
                end
                ade_pkg::OP_BYTE_DOT_SUB_RIGHT:
                begin
                    next_r.acc[accSel] = curAcc - dotRight;  // see RQ2
                    next_r.resData     = '0;
                    next_r.resFail     = 1'b0;
                end
                ade_pkg::OP_HALF_CROSS_DOT_SUB:
                begin
                    // wraps mod 2^64, ouflag left alone, see RQ17
                    next_r.acc[accSel] = curAcc - dotCross; // see RQ4, RQ5
                    next_r.resData     = '0;
                    next_r.resFail     = 1'b0;
                end
                ade_pkg::OP_FIXED_FIELD_EXTRACT,
                ade_pkg::OP_FIXED_FIELD_EXTRACT_DECREMENT:
                begin
                    // failure is only a flag, never a trap
                    next_r.resFail = !extValid;              // see RQ15
                    next_r.resData = extValid ? field : 32'h0;  // see RQ6
                    next_r.ctl[ade_pkg::EFI_BIT] = !extValid;   // see RQ9
                    setEv[ade_pkg::IRQ_EXT_FAIL] = !extValid;
                    if (opCode == ade_pkg::OP_FIXED_FIELD_EXTRACT_DECREMENT
                        && extValid)
                    begin
                        next_r.ctl[ade_pkg::POS_MSB:ade_pkg::POS_LSB] =
                            pos - {1'b0, sizeImm} - 6'h1;    // see RQ12
                    end
                    else
                    begin
                        next_r.ctl[ade_pkg::POS_MSB:ade_pkg::POS_LSB] =
                            pos;                             // see RQ11, RQ13
                    end
                end
                default:
                begin
                    next_r.resData = '0;
                    next_r.resFail = 1'b0;
                end
            endcase
        end
        // hardware set beats a same-cycle clear
        next_r.sts = next_r.sts | setEv;
        next_r.irq = |(next_r.sts & next_r.msk);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r         <= '0;
            r.ctl     <= ade_pkg::CTL_RESET;
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign resultValid   = r.resValid;
    assign resultData    = r.resData;
    assign extractFailed = r.resFail;
    assign irq           = r.irq;
    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [63:0] chkField;
    assign chkField = (curAcc >> (pos - {1'b0, sizeImm}))
                    & ((64'h1 << ({1'b0, sizeImm} + 6'h1)) - 64'h1);

    a_left_byte_sub: assert property ( // see RQ1
        go && opCode == ade_pkg::OP_BYTE_DOT_SUB_LEFT
        |=> r.acc[$past(accSel)] == $past(curAcc) - $past(dotLeft))
        else $error("left byte dot-subtract wrong");

    a_right_byte_sub: assert property ( // see RQ2
        go && opCode == ade_pkg::OP_BYTE_DOT_SUB_RIGHT
        |=> r.acc[$past(accSel)] == $past(curAcc) - $past(dotRight))
        else $error("right byte dot-subtract wrong");

    a_cross_half_sub: assert property ( // see RQ5
        go && opCode == ade_pkg::OP_HALF_CROSS_DOT_SUB
        |=> r.acc[$past(accSel)] == $past(curAcc) - $past(dotCross))
        else $error("cross halfword dot-subtract wrong");

    a_ouflag_kept: assert property ( // see RQ4
        go && !busWr && opCode inside {ade_pkg::OP_BYTE_DOT_SUB_LEFT,
            ade_pkg::OP_BYTE_DOT_SUB_RIGHT, ade_pkg::OP_HALF_CROSS_DOT_SUB}
        |=> $stable(r.ctl[ade_pkg::OUF_MSB:ade_pkg::OUF_LSB]))
        else $error("dot-subtract touched overflow flags");

    a_extract_value: assert property ( // see RQ6
        go && extValid && opCode inside {ade_pkg::OP_FIXED_FIELD_EXTRACT,
            ade_pkg::OP_FIXED_FIELD_EXTRACT_DECREMENT}
        |=> resultValid && resultData == $past(chkField[31:0]))
        else $error("extracted field wrong");

    a_efi_flag: assert property ( // see RQ9
        go && opCode inside {ade_pkg::OP_FIXED_FIELD_EXTRACT,
            ade_pkg::OP_FIXED_FIELD_EXTRACT_DECREMENT}
        |=> r.ctl[ade_pkg::EFI_BIT] == ($past(pos) < $past(sizeImm))
            && extractFailed == r.ctl[ade_pkg::EFI_BIT])
        else $error("extract-failed flag wrong");

    a_acc_kept: assert property ( // see RQ10
        go && !busWr && opCode inside {ade_pkg::OP_FIXED_FIELD_EXTRACT,
            ade_pkg::OP_FIXED_FIELD_EXTRACT_DECREMENT}
        |=> $stable(r.acc))
        else $error("extract modified an accumulator");

    a_pos_kept: assert property ( // see RQ11
        go && opCode == ade_pkg::OP_FIXED_FIELD_EXTRACT
        |=> r.ctl[ade_pkg::POS_MSB:ade_pkg::POS_LSB] == $past(pos))
        else $error("plain extract moved position");

    a_pos_decrement: assert property ( // see RQ12, RQ13
        go && opCode == ade_pkg::OP_FIXED_FIELD_EXTRACT_DECREMENT
        |=> r.ctl[ade_pkg::POS_MSB:ade_pkg::POS_LSB] == ($past(extValid)
            ? $past(pos) - 6'($past(sizeImm)) - 6'h1 : $past(pos)))
        else $error("decrementing extract position wrong");

    a_irq_level: assert property (
        ##1 irq == |(r.sts & r.msk))
        else $error("interrupt level mismatch");

endmodule // ade_core

// *** tb/ade_core_model.sv ***
`timescale 1ns/1ps

module ade_core_model
(
    input  wire logic        clk,
    output logic             opValid,
    output ade_pkg::ade_op_e opCode,
    output logic [1:0]       accSel,
    output logic [31:0]      srcOne,
    output logic [31:0]      srcTwo,
    output logic [4:0]       sizeImm
);
    initial
    begin
        opValid = 1'b0;
        opCode  = ade_pkg::OP_BYTE_DOT_SUB_LEFT;
        accSel  = 2'h0;
        srcOne  = 32'h0;
        srcTwo  = 32'h0;
        sizeImm = 5'h0;
    end

    // one op per call, operands in the format the op expects
    task automatic issue(input ade_pkg::ade_op_e op, input logic [1:0] sel,
        input logic [31:0] a, input logic [31:0] b, input logic [4:0] sz);
        @(posedge clk);
        opValid <= 1'b1;
        opCode  <= op;
        accSel  <= sel;
        srcOne  <= a;
        srcTwo  <= b;
        sizeImm <= sz;
        @(posedge clk);
        opValid <= 1'b0;
        // released operands must not keep a stale value
        srcOne  <= ~a;
        srcTwo  <= ~b;
    endtask
endmodule // ade_core_model

// *** tb/tb_acc_dot_subtract_extract.sv ***
`timescale 1ns/1ps

module tb_acc_dot_subtract_extract;
    logic clk, nrst, ce, resultValid, extractFailed, irq;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] resultData, awaddr, wdata, araddr, rdata, a, b, v, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r, sel;
    logic [4:0]  sz;
    logic        opValid, ef;
    logic [1:0]  accSel;
    logic [31:0] srcOne, srcTwo, ctl, ed;
    logic [4:0]  sizeImm;
    logic [63:0] accm;
    longint      s;
    int          numErrors, compares, p;
    ade_pkg::ade_op_e opCode, op;

    ade_core_model CORE (.clk(clk), .opValid(opValid), .opCode(opCode),
        .accSel(accSel), .srcOne(srcOne), .srcTwo(srcTwo), .sizeImm(sizeImm));

    ade_core DUT (.clk(clk), .nrst(nrst), .ce(ce), .opValid(opValid),
        .opCode(opCode), .accSel(accSel), .srcOne(srcOne), .srcTwo(srcTwo),
        .sizeImm(sizeImm), .resultValid(resultValid), .irq(irq),
        .resultData(resultData), .extractFailed(extractFailed),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // bus master and checking
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axw(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clk);
        awaddr  <= {24'h0, ad};
        wdata   <= dt;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // no fixed latency assumed; the watchdog ends a hang
        forever
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                bready <= 1'b0;
                r = bresp;
                break;
            end
        end
    endtask

    task automatic axr(input logic [7:0] ad);
        @(posedge clk);
        araddr  <= {24'h0, ad};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                rready <= 1'b0;
                d = rdata;
                r = rresp;
                break;
            end
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        numErrors++;
        final_report();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        {clk, nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        ce = 1'b1;
        wstrb = 4'hf;
        numErrors = 0;
        compares = 0;
        void'($urandom(32'h4c6b));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        axr(ade_pkg::ADDR_CONTROL);
        chk("control reset", ade_pkg::CTL_RESET, d);
        // only the lowest byte lane may land
        wstrb <= 4'h1;
        axw(ade_pkg::ADDR_CONTROL, 32'hffffffff);
        wstrb <= 4'hf;
        axr(ade_pkg::ADDR_CONTROL);
        chk("strobed control", 32'h000000ff & ade_pkg::CTL_WMASK, d);
        axr(8'h40);
        chk("unmapped rresp", ade_pkg::RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0, d);
        axw(8'h40, 32'hffffffff);
        chk("unmapped bresp", ade_pkg::RESP_SLVERR, r);
        $display("test register map done");
        for (int n = 0; n < 80; n++)
        begin
            sel = 2'($urandom);
            a = $urandom;
            b = $urandom;
            sz = 5'($urandom);
            v = $urandom;
            accm = {$urandom, $urandom};
            // hit the valid/failed boundary of the extract check often
            if (n % 4 == 0) v[5:0] = 6'(sz);
            if (n % 4 == 1) v[5:0] = 6'(sz) - 6'h1;
            op = ade_pkg::ade_op_e'(n % 5);
            axw(ade_pkg::ADDR_ACC_LO0 + 8'(8 * sel), accm[31:0]);
            axw(ade_pkg::ADDR_ACC_LO0 + 8'(8 * sel) + 8'h4, accm[63:32]);
            axw(ade_pkg::ADDR_CONTROL, v);
            ctl = v & ade_pkg::CTL_WMASK;
            ed = 32'h0;
            ef = 1'b0;
            p = int'(ctl[5:0]);
            s = longint'($signed(a[31:16])) * longint'($signed(b[15:0]))
                + longint'($signed(a[15:0])) * longint'($signed(b[31:16]));
            case (op)
                ade_pkg::OP_BYTE_DOT_SUB_LEFT: accm -= 64'(a[31:24] * b[31:24])
                    + 64'(a[23:16] * b[23:16]);
                ade_pkg::OP_BYTE_DOT_SUB_RIGHT: accm -= 64'(a[15:8] * b[15:8])
                    + 64'(a[7:0] * b[7:0]);
                ade_pkg::OP_HALF_CROSS_DOT_SUB: accm -= 64'(s);
                default:
                begin
                    ef = p < int'(sz);
                    ctl[14] = ef;
                    if (!ef) ed = 32'((accm >> (p - int'(sz)))
                        & ((64'h1 << (int'(sz) + 1)) - 64'h1));
                    if (!ef && op == ade_pkg::OP_FIXED_FIELD_EXTRACT_DECREMENT)
                        ctl[5:0] = ctl[5:0] - 6'(int'(sz) + 1);
                end
            endcase
            CORE.issue(op, sel, a, b, sz);
            #1;
            chk("resultValid", 32'h1, resultValid);
            chk("resultData", ed, resultData);
            chk("extractFailed", 32'(ef), extractFailed);
            axr(ade_pkg::ADDR_ACC_LO0 + 8'(8 * sel));
            chk("acc low", accm[31:0], d);
            axr(ade_pkg::ADDR_ACC_LO0 + 8'(8 * sel) + 8'h4);
            chk("acc high", accm[63:32], d);
            axr(ade_pkg::ADDR_CONTROL);
            chk("control", ctl, d);
        end
        $display("test operations done");
        // an op offered while ce is low must leave no trace
        axw(ade_pkg::ADDR_ACC_LO0 + 8'h8, 32'h5a);
        ce <= 1'b0;
        CORE.issue(ade_pkg::OP_BYTE_DOT_SUB_LEFT, 2'h1, 32'hff000000,
            32'hff000000, 5'h0);
        ce <= 1'b1;
        #1;
        chk("frozen resultValid", 32'h0, resultValid);
        axr(ade_pkg::ADDR_ACC_LO0 + 8'h8);
        chk("frozen acc low", 32'h5a, d);
        axw(ade_pkg::ADDR_IRQ_STS, 32'h3);
        axw(ade_pkg::ADDR_IRQ_MSK, 32'h1);
        axw(ade_pkg::ADDR_CONTROL, 32'h0);
        CORE.issue(ade_pkg::OP_FIXED_FIELD_EXTRACT, 2'h1, 32'h0, 32'h0, 5'h5);
        repeat (2) @(posedge clk);
        #1;
        chk("irq raised", 32'h1, irq);
        axr(ade_pkg::ADDR_IRQ_STS);
        chk("irq status", 32'h3, d);
        axw(ade_pkg::ADDR_IRQ_STS, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk("irq cleared", 32'h0, irq);
        axw(ade_pkg::ADDR_IRQ_MSK, 32'h0);
        CORE.issue(ade_pkg::OP_FIXED_FIELD_EXTRACT, 2'h2, 32'h0, 32'h0, 5'h3);
        repeat (2) @(posedge clk);
        #1;
        chk("irq masked", 32'h0, irq);
        $display("test interrupt done");
        final_report();
    end
endmodule // tb_acc_dot_subtract_extract
